/* File: core/ctab_pkg.sv */
// ==========================================================
// constants for the continuous-time block configuration bank
package ctab_pkg;

    // ==========================================================
    // array shape and bus widths
    localparam int NUM_BLK = 4;
    localparam int ADR_W   = 12;
    localparam int IDX_W   = 10;
    localparam int DAT_W   = 32;
    localparam int REG_W   = 8;
    localparam int TAP_N   = 16;
    localparam int BOT_N   = 4;
    localparam int MUX_N   = 7;

    // ==========================================================
    // register indices, byte address is four times the index
    localparam logic [9:0] IDX_CR0 [NUM_BLK] = '{10'h071, 10'h075, 10'h079, 10'h07D};
    localparam logic [9:0] IDX_CR1 [NUM_BLK] = '{10'h072, 10'h076, 10'h07A, 10'h07E};
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [31:0] UNMAPPED_RDATA = 32'h0000_0000;

    // ==========================================================
    // first control register fields
    localparam int TAP_MSB  = 7;
    localparam int TAP_LSB  = 4;
    localparam int TOPO_BIT = 3;
    localparam int TOP_BIT  = 2;
    localparam int BOT_MSB  = 1;
    localparam int BOT_LSB  = 0;

    // ==========================================================
    // second control register fields and codes
    localparam int ANA_BUS_BIT = 7;
    localparam int CMP_BUS_BIT = 6;
    localparam int NEG_MSB     = 5;
    localparam int NEG_LSB     = 3;
    localparam int POS_MSB     = 2;
    localparam int POS_LSB     = 0;
    localparam logic [2:0] POS_FLOAT    = 3'h7;
    localparam logic [2:0] NEG_RSVD     = 3'h7;
    localparam logic [2:0] NEG_FEEDBACK = 3'h4;

endpackage

/* File: core/ctab_block_decode.sv */
`timescale 1ns/1ps
// ==========================================================
// per-block field decoder, one-hot switch controls
module ctab_block_decode (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    // configuration bytes
    input  wire logic [7:0]  i_cr0,
    input  wire logic [7:0]  i_cr1,
    // decoded switch controls
    output logic      [15:0] o_tap_sel,
    output logic             o_gain_mode,
    output logic             o_top_to_out,
    output logic      [3:0]  o_bot_sel,
    output logic      [6:0]  o_pos_sel,
    output logic      [6:0]  o_neg_sel,
    output logic             o_ana_bus_en,
    output logic             o_cmp_bus_en
);

    typedef struct packed {
        logic [15:0] tap_sel;
        logic        gain_mode;
        logic        top_to_out;
        logic [3:0]  bot_sel;
        logic [6:0]  pos_sel;
        logic [6:0]  neg_sel;
        logic        ana_bus_en;
        logic        cmp_bus_en;
    } ctab_dec_state_type;

    ctab_dec_state_type state_ff;
    ctab_dec_state_type nxt_state;
    logic [2:0]         pos_code;
    logic [2:0]         neg_code;

    assign pos_code = i_cr1[ctab_pkg::POS_MSB:ctab_pkg::POS_LSB];
    assign neg_code = i_cr1[ctab_pkg::NEG_MSB:ctab_pkg::NEG_LSB];

    // ==========================================================
    // decode, registered so every control is glitch free
    always_comb begin
        nxt_state = '0;
        if (!i_rst) begin
            nxt_state.tap_sel    = 16'h0001 << i_cr0[ctab_pkg::TAP_MSB:ctab_pkg::TAP_LSB];
            nxt_state.gain_mode  = i_cr0[ctab_pkg::TOPO_BIT];
            nxt_state.top_to_out = i_cr0[ctab_pkg::TOP_BIT];
            nxt_state.bot_sel    = 4'h1 << i_cr0[ctab_pkg::BOT_MSB:ctab_pkg::BOT_LSB];
            // floating code closes no switch at all
            if (pos_code != ctab_pkg::POS_FLOAT) begin
                nxt_state.pos_sel = 7'h01 << pos_code;
            end
            // slot four is the own-output feedback path
            if (neg_code != ctab_pkg::NEG_RSVD) begin
                nxt_state.neg_sel = 7'h01 << neg_code;
            end
            nxt_state.ana_bus_en = i_cr1[ctab_pkg::ANA_BUS_BIT];
            nxt_state.cmp_bus_en = i_cr1[ctab_pkg::CMP_BUS_BIT];
        end
    end

    always_ff @(posedge i_clk) begin
        state_ff <= nxt_state;
    end

    // outputs straight from the state flops
    assign o_tap_sel    = state_ff.tap_sel;
    assign o_gain_mode  = state_ff.gain_mode;
    assign o_top_to_out = state_ff.top_to_out;
    assign o_bot_sel    = state_ff.bot_sel;
    assign o_pos_sel    = state_ff.pos_sel;
    assign o_neg_sel    = state_ff.neg_sel;
    assign o_ana_bus_en = state_ff.ana_bus_en;
    assign o_cmp_bus_en = state_ff.cmp_bus_en;

    // ==========================================================
    // checks on the decode
    a_tap_decode: assert property (@(posedge i_clk) disable iff (i_rst)
        !$past(i_rst) |-> o_tap_sel == (16'h0001 << $past(i_cr0[7:4])))
        else $error("tap select does not match field");
    a_bottom_route: assert property (@(posedge i_clk) disable iff (i_rst)
        !$past(i_rst) |-> o_bot_sel == (4'h1 << $past(i_cr0[1:0])))
        else $error("bottom route not one-hot of field");
    a_pos_float: assert property (@(posedge i_clk) disable iff (i_rst)
        ($past(i_cr1[2:0]) == 3'h7 && !$past(i_rst)) |-> o_pos_sel == 7'h00)
        else $error("floating positive code closed a switch");
    a_neg_feedback: assert property (@(posedge i_clk) disable iff (i_rst)
        ($past(i_cr1[5:3]) == 3'h4 && !$past(i_rst)) |-> o_neg_sel == 7'h10)
        else $error("feedback code did not select own output");
    a_bus_enables: assert property (@(posedge i_clk) disable iff (i_rst)
        !$past(i_rst) |-> {o_ana_bus_en, o_cmp_bus_en} == $past(i_cr1[7:6]))
        else $error("bus enables do not follow register");

endmodule

/* File: core/ctab_config_bank.sv */
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ps
// Functional notes
// - tap field bits 7..4 picks one of sixteen resistor taps.
// - bit 3 chooses loss or gain topology for the centre tap.
// - bit 2 routes resistor top to supply or op-amp output.
// - bits 1..0 route resistor bottom to neighbour, ground, negative supply, below.
// - positive input field bits 2..0 selects one of seven sources.
// - positive code 111 connects nothing; software should not use it.
// - negative input field bits 5..3 selects seven sources; 111 reserved.
// - negative code 100 connects the block's own output feedback.
// - bit 7 closes the op-amp to column analog bus switch.
// - bit 6 enables the comparator driver onto the column bus.
// - an undriven column comparator bus is held low.
// - registers at 71h,75h,79h,7Dh and next address, any bank.
module ctab_config_bank (
    // clock and reset
    input  wire logic                I_CLK,
    input  wire logic                I_SYS_RST,
    // wishbone slave
    input  wire logic                I_WB_CYC,
    input  wire logic                I_WB_STB,
    input  wire logic                I_WB_WE,
    input  wire logic [11:0]         I_WB_ADR,
    input  wire logic [3:0]          I_WB_SEL,
    input  wire logic [31:0]         I_WB_DAT,
    output logic      [31:0]         O_WB_DAT,
    output logic                     O_WB_ACK,
    // comparator results and drive requests from outside the clock domain
    input  wire logic [3:0]          I_CT_CMP_RESULT,
    input  wire logic [3:0]          I_SC_CMP_DRIVE,
    input  wire logic [3:0]          I_SC_CMP_RESULT,
    // resistor string controls, one entry per block
    output logic      [3:0][15:0]    O_RESISTOR_TAP_SELECT,
    output logic      [3:0]          O_GAIN_MODE,
    output logic      [3:0]          O_RESISTOR_TOP_ROUTE,
    output logic      [3:0][3:0]     O_RESISTOR_BOTTOM_ROUTE,
    // op-amp input selects, one-hot
    output logic      [3:0][6:0]     O_POSITIVE_INPUT_SELECT,
    output logic      [3:0][6:0]     O_NEGATIVE_INPUT_SELECT,
    // column bus controls
    output logic      [3:0]          O_ANALOG_BUS_DRIVE_EN,
    output logic      [3:0]          O_COMPARATOR_BUS_DRIVE_EN,
    output logic      [3:0]          O_COLUMN_COMPARATOR_BUS
);

    // ==========================================================
    // state
    typedef struct packed {
        logic [3:0][7:0] cr0;
        logic [3:0][7:0] cr1;
        logic            wb_ack;
        logic [31:0]     wb_rdat;
        logic [3:0]      ct_cmp_s1;
        logic [3:0]      ct_cmp_s2;
        logic [3:0]      sc_drv_s1;
        logic [3:0]      sc_drv_s2;
        logic [3:0]      sc_cmp_s1;
        logic [3:0]      sc_cmp_s2;
        logic [3:0]      col_bus;
    } ctab_bank_state_type;

    ctab_bank_state_type state_ff;
    ctab_bank_state_type nxt_state;
    logic [9:0]          req_idx;
    logic                req_take;

    // word index; low two address bits are don't care
    assign req_idx  = I_WB_ADR[11:2];
    // one access per request, the ack cycle itself is not a new one
    assign req_take = I_WB_CYC && I_WB_STB && !state_ff.wb_ack;

    // ==========================================================
    // next state
    always_comb begin
        nxt_state = state_ff;
        nxt_state.wb_ack  = 1'b0;
        nxt_state.wb_rdat = ctab_pkg::UNMAPPED_RDATA;

        // two-flop synchronisers, first stage read only here
        nxt_state.ct_cmp_s1 = I_CT_CMP_RESULT;
        nxt_state.ct_cmp_s2 = state_ff.ct_cmp_s1;
        nxt_state.sc_drv_s1 = I_SC_CMP_DRIVE;
        nxt_state.sc_drv_s2 = state_ff.sc_drv_s1;
        nxt_state.sc_cmp_s1 = I_SC_CMP_RESULT;
        nxt_state.sc_cmp_s2 = state_ff.sc_cmp_s1;

        // column comparator bus: own driver, else the other
        // block, else pulled low so the digital side never
        // sees a floating level
        for (int k = 0; k < ctab_pkg::NUM_BLK; k++) begin
            if (O_COMPARATOR_BUS_DRIVE_EN[k]) begin
                nxt_state.col_bus[k] = state_ff.ct_cmp_s2[k];
            end else if (state_ff.sc_drv_s2[k]) begin
                nxt_state.col_bus[k] = state_ff.sc_cmp_s2[k];
            end else begin
                nxt_state.col_bus[k] = 1'b0;
            end
        end

        // bus access; unmapped words ack, read zero, drop writes
        if (req_take) begin
            nxt_state.wb_ack = 1'b1;
            for (int k = 0; k < ctab_pkg::NUM_BLK; k++) begin
                // same map whatever bank software believes it is in
                if (req_idx == ctab_pkg::IDX_CR0[k]) begin
                    nxt_state.wb_rdat = {24'h00_0000, state_ff.cr0[k]};
                    if (I_WB_WE && I_WB_SEL[0]) begin
                        nxt_state.cr0[k] = I_WB_DAT[7:0];
                    end
                end
                if (req_idx == ctab_pkg::IDX_CR1[k]) begin
                    nxt_state.wb_rdat = {24'h00_0000, state_ff.cr1[k]};
                    if (I_WB_WE && I_WB_SEL[0]) begin
                        nxt_state.cr1[k] = I_WB_DAT[7:0];
                    end
                end
            end
        end

        // synchronous reset clears all configuration
        if (I_SYS_RST) begin
            nxt_state = '0;
            for (int k = 0; k < ctab_pkg::NUM_BLK; k++) begin
                nxt_state.cr0[k] = ctab_pkg::REG_RST;
                nxt_state.cr1[k] = ctab_pkg::REG_RST;
            end
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge I_CLK) begin
        state_ff <= nxt_state;
    end

    // bus answer and comparator bus straight from flops
    assign O_WB_ACK                = state_ff.wb_ack;
    assign O_WB_DAT                = state_ff.wb_rdat;
    assign O_COLUMN_COMPARATOR_BUS = state_ff.col_bus;

    // ==========================================================
    // one decoder per block; decode sits a cycle after the
    // register so a write never shows a half-updated mux
    for (genvar k = 0; k < ctab_pkg::NUM_BLK; k++) begin : g_blk
        ctab_block_decode u_dec (
            .i_clk        (I_CLK),
            .i_rst        (I_SYS_RST),
            .i_cr0        (state_ff.cr0[k]),
            .i_cr1        (state_ff.cr1[k]),
            .o_tap_sel    (O_RESISTOR_TAP_SELECT[k]),
            .o_gain_mode  (O_GAIN_MODE[k]),
            .o_top_to_out (O_RESISTOR_TOP_ROUTE[k]),
            .o_bot_sel    (O_RESISTOR_BOTTOM_ROUTE[k]),
            .o_pos_sel    (O_POSITIVE_INPUT_SELECT[k]),
            .o_neg_sel    (O_NEGATIVE_INPUT_SELECT[k]),
            .o_ana_bus_en (O_ANALOG_BUS_DRIVE_EN[k]),
            .o_cmp_bus_en (O_COMPARATOR_BUS_DRIVE_EN[k])
        );
    end

    // ==========================================================
    // checks
    sequence s_take;
        I_WB_CYC && I_WB_STB && !O_WB_ACK;
    endsequence

    sequence s_wr_blk0_cr0;
        s_take ##0 I_WB_WE && I_WB_SEL[0] && I_WB_ADR == 12'h1C4;
    endsequence

    sequence s_rd_blk3_cr1;
        s_take ##0 !I_WB_WE && I_WB_ADR == 12'h1F8;
    endsequence

    a_ack_pulse: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        s_take |=> O_WB_ACK ##1 !O_WB_ACK)
        else $error("ack not a single cycle after request");

    a_map_write: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        s_wr_blk0_cr0 |=> state_ff.cr0[0] == $past(I_WB_DAT[7:0]))
        else $error("write to first block register lost");

    a_read_back: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        s_rd_blk3_cr1 |=> O_WB_ACK && O_WB_DAT == {24'h00_0000, $past(state_ff.cr1[3])})
        else $error("read data differs from stored value");

    a_reset_clear: assert property (@(posedge I_CLK)
        $past(I_SYS_RST) |-> state_ff.cr0 == '0 && state_ff.cr1 == '0)
        else $error("registers not cleared by reset");

    a_decode_lag: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        s_wr_blk0_cr0 ##1 1'b1 |=> O_GAIN_MODE[0] == $past(I_WB_DAT[3], 2))
        else $error("topology bit did not reach switch two cycles after write");

    a_top_route: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        s_wr_blk0_cr0 ##1 1'b1 |=> O_RESISTOR_TOP_ROUTE[0] == $past(I_WB_DAT[2], 2))
        else $error("top route bit did not reach switch");

    a_pos_select: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        !$past(I_SYS_RST) && !$past(I_SYS_RST, 2) && $past(state_ff.cr1[1][2:0]) != 3'h7
        |-> O_POSITIVE_INPUT_SELECT[1] == (7'h01 << $past(state_ff.cr1[1][2:0])))
        else $error("positive select not one-hot of field");

    a_neg_select: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        !$past(I_SYS_RST) && !$past(I_SYS_RST, 2) && $past(state_ff.cr1[2][5:3]) == 3'h7
        |-> O_NEGATIVE_INPUT_SELECT[2] == 7'h00)
        else $error("reserved negative code closed a switch");

    a_cmp_bus_low: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        !$past(I_SYS_RST) |->
        (O_COLUMN_COMPARATOR_BUS & ~$past(O_COMPARATOR_BUS_DRIVE_EN) & ~$past(state_ff.sc_drv_s2)) == 4'h0)
        else $error("undriven comparator bus not low");

    a_cmp_bus_own: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        !$past(I_SYS_RST) && $past(O_COMPARATOR_BUS_DRIVE_EN[0])
        |-> O_COLUMN_COMPARATOR_BUS[0] == $past(state_ff.ct_cmp_s2[0]))
        else $error("own comparator result not on bus");

endmodule

/* File: test/ctab_config_bank_tb_top.sv */
`timescale 1ns/1ps
// ==========================================================
// self-checking bench for the configuration bank
module ctab_config_bank_tb_top;
    logic                clk;
    logic                sys_rst;
    logic                wb_cyc;
    logic                wb_stb;
    logic                wb_we;
    logic [11:0]         wb_adr;
    logic [3:0]          wb_sel;
    logic [31:0]         wb_wdat;
    logic [31:0]         wb_rdat;
    logic                wb_ack;
    logic [3:0]          ct_cmp;
    logic [3:0]          sc_drv;
    logic [3:0]          sc_res;
    logic [3:0][15:0]    tap_sel;
    logic [3:0]          gain;
    logic [3:0]          top;
    logic [3:0][3:0]     bot;
    logic [3:0][6:0]     pos_sel;
    logic [3:0][6:0]     neg_sel;
    logic [3:0]          ana_en;
    logic [3:0]          cmp_en;
    logic [3:0]          col_bus;
    int                  n_mismatch = 0;
    int                  checks = 0;
    logic [7:0]          rd;

    ctab_config_bank i_dut (
        .I_CLK(clk), .I_SYS_RST(sys_rst), .I_WB_CYC(wb_cyc), .I_WB_STB(wb_stb), .I_WB_WE(wb_we),
        .I_WB_ADR(wb_adr), .I_WB_SEL(wb_sel), .I_WB_DAT(wb_wdat), .O_WB_DAT(wb_rdat), .O_WB_ACK(wb_ack),
        .I_CT_CMP_RESULT(ct_cmp), .I_SC_CMP_DRIVE(sc_drv), .I_SC_CMP_RESULT(sc_res),
        .O_RESISTOR_TAP_SELECT(tap_sel), .O_GAIN_MODE(gain), .O_RESISTOR_TOP_ROUTE(top),
        .O_RESISTOR_BOTTOM_ROUTE(bot), .O_POSITIVE_INPUT_SELECT(pos_sel), .O_NEGATIVE_INPUT_SELECT(neg_sel),
        .O_ANALOG_BUS_DRIVE_EN(ana_en), .O_COMPARATOR_BUS_DRIVE_EN(cmp_en), .O_COLUMN_COMPARATOR_BUS(col_bus)
    );

    // ==========================================================
    // clock and shared tasks
    initial clk = 1'b0;
    always #4 clk = ~clk;

    // compare and count, four-state exact
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // classic single wishbone cycle; ack and read data sampled at the same rising edge
    task automatic wb(input logic we_in, input logic [11:0] adr_in, input logic [7:0] wd, output logic [7:0] rdv);
        int n;
        n = 0;
        @(posedge clk);
        wb_cyc  <= 1'b1;
        wb_stb  <= 1'b1;
        wb_we   <= we_in;
        wb_adr  <= adr_in;
        wb_sel  <= 4'h1;
        wb_wdat <= {24'h00_0000, wd};
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 64);
        rdv = wb_rdat[7:0];
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
        // a slave that never answers ends the run here
        if (wb_ack !== 1'b1) begin
            n_mismatch++;
            report_and_stop();
        end
    endtask

    // byte address of a block register: first control at 71h + 4*blk, word-indexed
    function automatic logic [11:0] adr_of(input int blk, input int which);
        return 12'h1C4 + 12'(blk * 16) + 12'(which * 4);
    endfunction

    // ==========================================================
    // scenarios
    task automatic t_reset_values();
        for (int b = 0; b < 4; b++) begin
            wb(1'b0, adr_of(b, 0), 8'h00, rd);
            chk({24'h0, rd}, 32'h0000_0000);
            wb(1'b0, adr_of(b, 1), 8'h00, rd);
            chk({24'h0, rd}, 32'h0000_0000);
            chk({16'h0, tap_sel[b]}, 32'h0000_0001);
            chk({25'h0, pos_sel[b]}, 32'h0000_0001);
        end
    endtask

    // every register holds its own value; unmapped places read zero and keep nothing
    task automatic t_map_readback();
        for (int b = 0; b < 4; b++) begin
            wb(1'b1, adr_of(b, 0), 8'hA0 + 8'(b), rd);
            wb(1'b1, adr_of(b, 1), 8'h5C - 8'(b), rd);
        end
        wb(1'b1, 12'h1C0, 8'hFF, rd);
        wb(1'b1, 12'h1CC, 8'hFF, rd);
        for (int b = 0; b < 4; b++) begin
            wb(1'b0, adr_of(b, 0), 8'h00, rd);
            chk({24'h0, rd}, {24'h0, 8'hA0 + 8'(b)});
            wb(1'b0, adr_of(b, 1), 8'h00, rd);
            chk({24'h0, rd}, {24'h0, 8'h5C - 8'(b)});
        end
        wb(1'b0, 12'h1C0, 8'h00, rd);
        chk({24'h0, rd}, 32'h0000_0000);
        wb(1'b0, 12'h1CC, 8'h00, rd);
        chk({24'h0, rd}, 32'h0000_0000);
    endtask

    // all sixteen taps, both topologies, both top routes, all bottom codes
    task automatic t_resistor_decode();
        int b;
        logic [7:0] v;
        for (int t = 0; t < 16; t++) begin
            b = t % 4;
            v = {4'(t), 1'(t & 1), 1'((t >> 1) & 1), 2'(t % 4)};
            wb(1'b1, adr_of(b, 0), v, rd);
            repeat (2) @(negedge clk);
            chk({16'h0, tap_sel[b]}, 32'h1 << t);
            chk({31'h0, gain[b]}, {31'h0, v[3]});
            chk({31'h0, top[b]}, {31'h0, v[2]});
            chk({28'h0, bot[b]}, 32'h1 << (t % 4));
        end
    endtask

    // all positive and negative codes, floating and reserved give no switch
    task automatic t_input_decode();
        int b;
        logic [7:0] v;
        for (int c = 0; c < 8; c++) begin
            b = c % 4;
            v = {1'(c & 1), 1'b0, 3'(7 - c), 3'(c)};
            wb(1'b1, adr_of(b, 1), v, rd);
            repeat (2) @(negedge clk);
            chk({25'h0, pos_sel[b]}, (c == 7) ? 32'h0 : 32'h1 << c);
            chk({25'h0, neg_sel[b]}, (c == 0) ? 32'h0 : 32'h1 << (7 - c));
            chk({31'h0, ana_en[b]}, {31'h0, v[7]});
        end
    endtask

    // comparator bus: own driver, other driver, and nobody driving
    task automatic t_comparator_bus();
        wb(1'b1, adr_of(2, 1), 8'h40, rd);
        ct_cmp <= 4'h4;
        repeat (6) @(posedge clk);
        chk({31'h0, cmp_en[2]}, 32'h0000_0001);
        chk({28'h0, col_bus}, 32'h0000_0004);
        ct_cmp <= 4'h0;
        repeat (6) @(posedge clk);
        chk({28'h0, col_bus}, 32'h0000_0000);
        wb(1'b1, adr_of(2, 1), 8'h00, rd);
        ct_cmp <= 4'hF;
        sc_drv <= 4'h2;
        sc_res <= 4'h2;
        repeat (6) @(posedge clk);
        chk({28'h0, cmp_en}, 32'h0000_0000);
        chk({28'h0, col_bus}, 32'h0000_0002);
        sc_drv <= 4'h0;
        repeat (6) @(posedge clk);
        chk({28'h0, col_bus}, 32'h0000_0000);
    endtask

    // ==========================================================
    // verdict, main sequence and watchdog
    task automatic report_and_stop();
        $display("mismatches=%0d comparisons=%0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        sys_rst = 1'b1;
        wb_cyc  = 1'b0;
        wb_stb  = 1'b0;
        wb_we   = 1'b0;
        wb_adr  = 12'h000;
        wb_sel  = 4'h0;
        wb_wdat = 32'h0000_0000;
        ct_cmp  = 4'h0;
        sc_drv  = 4'h0;
        sc_res  = 4'h0;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk);
        t_reset_values();
        t_map_readback();
        t_resistor_decode();
        t_input_decode();
        t_comparator_bus();
        report_and_stop();
    end

    // about 54 bus cycles of work; far more than enough margin
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        report_and_stop();
    end
endmodule
